// [hw/line_ctrl_pkg.sv]
// constants and types shared by the line state controller files
//
// Contract
// [R1] device decodes three-bit code into line states
// [R2] controller never applies reserved code 101
// [R3] thermal shutdown forces hook and ground key low
// [R4] open circuit holds both detector outputs high
// [R5] grounded sync input energises relay at once
// [R6] pulsed sync input energises relay on pulse
// [R7] sync pulse low at zero crossing, 2 ms
// [R8] device releases relay near zero ring current
// [R9] off-hook while ringing pulls hook output low
// [R10] ring trip latch blocks ringing until re-entry
// [R11] never go from reverse directly to ringing
// [R12] reverse-to-ringing looks like off-hook, inhibits ring
// [R13] ground key output held high while ringing
// [R14] enter test active only from forward active
// [R15] enter test reversal only from reverse active
// [R16] test on-hook entry: loopback, hook output low
// [R17] test reversal on-hook: ground key high
// [R18] tip open state reports ground key detector
// [R19] forward and reverse keep both detectors active
// [R20] tip open ring ground pulls both low
// [R21] test off-hook entry: ground key pulse train
`default_nettype none
package line_ctrl_pkg;

  localparam int CLK_HZ = 200_000_000;

  // line state codes
  localparam logic [2:0] CODE_OPEN    = 3'h0;
  localparam logic [2:0] CODE_RING    = 3'h1;
  localparam logic [2:0] CODE_FWD     = 3'h2;
  localparam logic [2:0] CODE_TEST    = 3'h3;
  localparam logic [2:0] CODE_TIPOPEN = 3'h4;
  localparam logic [2:0] CODE_RSVD    = 3'h5;
  localparam logic [2:0] CODE_REV     = 3'h6;
  localparam logic [2:0] CODE_TESTREV = 3'h7;

  // register byte addresses
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;

  // control register fields
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_SYNC_BIT = 3;
  // status register fields
  localparam int ST_CODE_LSB  = 0;
  localparam int ST_BUSY_BIT  = 3;
  localparam int ST_HOOK_BIT  = 4;
  localparam int ST_GKEY_BIT  = 5;
  localparam int ST_RELAY_BIT = 6;
  localparam int ST_TRIP_BIT  = 7;
  localparam int ST_BAD_BIT   = 8;

  // reset values
  localparam logic [2:0] RESET_CODE = CODE_OPEN;
  localparam logic       RESET_SYNC = 1'b0;

  // timing
  localparam int RING_SYNC_MIN_MS = 2;
  localparam int RING_SYNC_CYCLES = RING_SYNC_MIN_MS * (CLK_HZ / 1000);
  localparam int SETTLE_US        = 100;
  localparam int SETTLE_CYCLES    = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W            = 20;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_APPLY  = 2'b01,
    ST_SETTLE = 2'b11
  } seq_state_t;

endpackage
`default_nettype wire

// [hw/ring_sync_if.sv]
// carrier between the sequencer and the ring sync pulse generator
`timescale 1ns/1ps
`default_nettype none
interface ring_sync_if;
  logic fire;
  logic hold;
  logic lineLow;
  logic busy;
  modport gen (input fire, input hold, output lineLow, output busy);
  modport ctl (output fire, output hold, input lineLow, input busy);
endinterface
`default_nettype wire

// [hw/ring_sync_gen.sv]
// ring sync pulse generator: fixed low pulse or steady low level
`timescale 1ns/1ps
`default_nettype none
module ring_sync_gen
  import line_ctrl_pkg::*;
#(
  parameter int PULSE_CYCLES = RING_SYNC_CYCLES
) (
  // clocking
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic ce,
  // sequencer side
  ring_sync_if.gen  sync
);

  logic [CNT_W-1:0] count_reg;
  logic             low_reg;

  assign sync.lineLow = low_reg;
  assign sync.busy    = low_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= '0;
      low_reg   <= 1'b0;
    end else if (ce) begin
      if (sync.hold) begin
        // steady low stands in for the resistor to ground
        low_reg   <= 1'b1; // [R5]
        count_reg <= '0;
      end else if (sync.fire && !low_reg) begin
        low_reg   <= 1'b1; // [R7]
        count_reg <= CNT_W'(PULSE_CYCLES - 1);
      end else if (count_reg != '0) begin
        count_reg <= count_reg - 1'b1;
      end else begin
        low_reg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [hw/line_state_controller.sv]
// line card controller: sequences state code pins, watches detectors
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module line_state_controller
  import line_ctrl_pkg::*;
#(
  parameter int PULSE_CYCLES = RING_SYNC_CYCLES,
  parameter int SETTLE_CYC   = SETTLE_CYCLES
) (
  // clocking
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // state code pins to the line interface
  output logic             state_code_bit2,
  output logic             state_code_bit1,
  output logic             state_code_bit0,
  output logic             ring_sync_input,
  // detector pins from the line interface
  input  wire logic        hook_detect_n,
  input  wire logic        ground_key_measure_n,
  input  wire logic        ring_relay_drive_n,
  // zero crossing strobe from the ring generator
  input  wire logic        zeroCross
);

  ring_sync_if sync ();

  ring_sync_gen #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ce      (ce),
    .sync    (sync.gen)
  );

  logic [2:0]       target_reg;
  logic             syncMode_reg;
  logic [2:0]       applied_reg;
  logic [2:0]       hop_next;
  seq_state_t       state_reg;
  logic [CNT_W-1:0] settle_reg;
  logic             trip_reg;
  logic             bad_reg;
  logic             ack_reg;
  logic [31:0]      rdata_reg;
  logic             busy;
  logic             access;
  logic             wrCtrl;
  logic             wrStatus;
  logic             tripEvent;
  logic             badEvent;
  logic             clrTrip;
  logic             clrBad;
  logic [31:0]      ctrlWord;
  logic [31:0]      statusWord;

  assign access   = cyc_i && stb_i && !ack_reg;
  assign wrCtrl   = access && we_i && adr_i == ADDR_CTRL && sel_i[0];
  assign wrStatus = access && we_i && adr_i == ADDR_STATUS;
  assign busy     = state_reg != ST_IDLE || applied_reg != target_reg;
  assign ack_o    = ack_reg;
  assign dat_o    = rdata_reg;

  assign state_code_bit2 = applied_reg[2];
  assign state_code_bit1 = applied_reg[1];
  assign state_code_bit0 = applied_reg[0];
  assign ring_sync_input = ~sync.lineLow;

  // the reserved code is refused and the old target kept
  assign badEvent = wrCtrl
    && dat_i[CTRL_CODE_LSB +: 3] == CODE_RSVD; // [R2]

  // write one to clear; each flag byte is picked by its own select
  assign clrTrip = wrStatus && sel_i[0] && dat_i[ST_TRIP_BIT];
  assign clrBad  = wrStatus && sel_i[1] && dat_i[ST_BAD_BIT];

  // next code on the way to the target; detours through the
  // matching active state so the device sees a valid entry
  always_comb begin
    hop_next = target_reg;
    if (target_reg == CODE_RING && applied_reg == CODE_REV) begin
      // a direct hop would falsely trip and inhibit ringing
      hop_next = CODE_FWD; // [R11] [R12]
    end else if (target_reg == CODE_TEST
                 && applied_reg != CODE_FWD) begin
      hop_next = CODE_FWD; // [R14]
    end else if (target_reg == CODE_TESTREV
                 && applied_reg != CODE_REV) begin
      hop_next = CODE_REV; // [R15]
    end
  end

  // software control register; the sync mode bit is taken even
  // when the code is refused, so the mode can be set up first
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      target_reg   <= RESET_CODE;
      syncMode_reg <= RESET_SYNC;
    end else if (ce) begin
      if (wrCtrl) begin
        syncMode_reg <= dat_i[CTRL_SYNC_BIT];
        if (!badEvent) begin
          target_reg <= dat_i[CTRL_CODE_LSB +: 3];
        end
      end
    end
  end

  // sequencer: one code change, then a settle time before the next
  // hop, so the device has a steady line when it captures the hook
  // state on entry to a test state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg   <= ST_IDLE;
      applied_reg <= RESET_CODE;
      settle_reg  <= '0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (applied_reg != target_reg) begin
            state_reg <= ST_APPLY;
          end
        end
        ST_APPLY: begin
          applied_reg <= hop_next;
          settle_reg  <= CNT_W'(SETTLE_CYC - 1);
          state_reg   <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (settle_reg != '0) begin
            settle_reg <= settle_reg - 1'b1;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ring sync drive only while ringing is applied; a running pulse
  // can be cut short by a write that clears the sync mode bit, as hold zeroes its count and the low then ends once hold drops
  always_comb begin
    sync.hold = applied_reg == CODE_RING && !syncMode_reg; // [R5]
    sync.fire = applied_reg == CODE_RING && syncMode_reg
      && zeroCross && !sync.busy; // [R6] [R7]
  end

  // ring trip: hook output low while ringing has settled; the
  // device then refuses ringing until the code is reapplied
  assign tripEvent = applied_reg == CODE_RING && state_reg == ST_IDLE
    && !hook_detect_n; // [R9] [R10]

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trip_reg <= 1'b0;
      bad_reg  <= 1'b0;
    end else if (ce) begin
      if (tripEvent) begin
        trip_reg <= 1'b1;
      end else if (clrTrip) begin
        trip_reg <= 1'b0;
      end
      if (badEvent) begin
        bad_reg <= 1'b1;
      end else if (clrBad) begin
        bad_reg <= 1'b0;
      end
    end
  end

  // read words are built apart from the bus timing
  always_comb begin
    ctrlWord                     = 32'h0000_0000;
    ctrlWord[CTRL_CODE_LSB +: 3] = target_reg;
    ctrlWord[CTRL_SYNC_BIT]      = syncMode_reg;
  end

  // detector pins are levels from the device and, save the hook pin read
  // by the ring trip logic, are only looked at here, so need no edge logic
  always_comb begin
    statusWord                   = 32'h0000_0000;
    statusWord[ST_CODE_LSB +: 3] = applied_reg;
    statusWord[ST_BUSY_BIT]      = busy;
    statusWord[ST_HOOK_BIT]      = hook_detect_n;
    statusWord[ST_GKEY_BIT]      = ground_key_measure_n;
    statusWord[ST_RELAY_BIT]     = ring_relay_drive_n;
    statusWord[ST_TRIP_BIT]      = trip_reg;
    statusWord[ST_BAD_BIT]       = bad_reg;
  end

  // bus answer one cycle after the request, dropped the next
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      ack_reg   <= access;
      rdata_reg <= 32'h0000_0000;
      if (access && !we_i) begin
        if (adr_i == ADDR_CTRL) begin
          rdata_reg <= ctrlWord;
        end else if (adr_i == ADDR_STATUS) begin
          rdata_reg <= statusWord;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [sim/line_ctrl_monitor.sv]
// port assertions for the line state controller
`timescale 1ns/1ps
`default_nettype none
module line_ctrl_monitor
  import line_ctrl_pkg::*;
#(
  parameter int PULSE_CYCLES = RING_SYNC_CYCLES
) (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        state_code_bit2,
  input wire logic        state_code_bit1,
  input wire logic        state_code_bit0,
  input wire logic        ring_sync_input,
  input wire logic        zeroCross
);
  wire [2:0] code = {state_code_bit2, state_code_bit1, state_code_bit0};
  logic [31:0] lowCnt;
  logic        pulsed;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clock) begin
    if (sys_rst) lowCnt <= 32'h0;
    else lowCnt <= ring_sync_input ? 32'h0 : lowCnt + 32'h1;
  end
  // shadow of the sync mode bit, taken at the accepting edge of a write
  always_ff @(posedge clock) begin
    if (sys_rst) pulsed <= 1'b0;
    else if (ack_o && we_i && adr_i == ADDR_CTRL && sel_i[0])
      pulsed <= dat_i[CTRL_SYNC_BIT];
  end
  chk_no_reserved: assert property (code != CODE_RSVD)
    else $error("reserved code driven");
  chk_rev_ring: assert property (
    $past(code) == CODE_REV |-> code != CODE_RING)
    else $error("reverse went straight to ringing");
  chk_test_entry: assert property (
    code == CODE_TEST && $past(code) != CODE_TEST
    |-> $past(code) == CODE_FWD)
    else $error("test entered not from forward");
  chk_testrev_entry: assert property (
    code == CODE_TESTREV && $past(code) != CODE_TESTREV
    |-> $past(code) == CODE_REV)
    else $error("test reversal entered not from reverse");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_read_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  chk_pulse_width: assert property (
    $rose(ring_sync_input) && $past(code) == CODE_RING
    |-> lowCnt == PULSE_CYCLES)
    else $error("sync pulse width wrong");
  chk_zc_start: assert property (
    pulsed && code == CODE_RING && zeroCross && ring_sync_input
    |=> !ring_sync_input)
    else $error("zero crossing did not start pulse");
  chk_steady_low: assert property (
    !pulsed && code == CODE_RING && $past(code) == CODE_RING
    |-> !ring_sync_input)
    else $error("steady sync not low in ringing");
  cover property ($rose(ring_sync_input) && $past(code) == CODE_RING);
  cover property (code == CODE_TEST && $past(code) == CODE_FWD);
  cover property (code == CODE_RING && $past(code) == CODE_FWD);
endmodule
bind line_state_controller line_ctrl_monitor #(
  .PULSE_CYCLES(PULSE_CYCLES)
) i_line_ctrl_monitor (.clock, .sys_rst, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .state_code_bit2, .state_code_bit1,
  .state_code_bit0, .ring_sync_input, .zeroCross);
`default_nettype wire

// [sim/line_device_model.sv]
// behavioural line interface device answering the state code pins
`timescale 1ns/1ps
`default_nettype none
module line_device_model (
  // pins from the controller
  input  wire logic       clock,
  input  wire logic [2:0] code,
  input  wire logic       rsi,
  // line conditions from the bench
  input  wire logic       hot,
  input  wire logic       offHook,
  input  wire logic       gndKey,
  // detector outputs
  output logic            hookN,
  output logic            gkN,
  output logic            relayN
);
  logic [2:0] prev = 3'h0;
  logic       inhibit = 1'b0, armed = 1'b0, entryOff = 1'b0, tick = 1'b0;
  // the real part is clockless; the clock orders latch updates and paces the ground key pulse train
  always @(posedge clock) begin
    tick <= ~tick;
    if (code != prev) begin
      prev <= code;
      entryOff <= offHook;
    end
  end
  always @(posedge clock) begin
    if (code != 3'h1) inhibit <= 1'b0;
    else if (offHook || prev == 3'h6) inhibit <= 1'b1;
  end
  always @(posedge clock) begin
    if (code != 3'h1 || inhibit || offHook) armed <= 1'b0;
    else if (!rsi) armed <= 1'b1;
  end
  assign relayN = ~armed;
  always_comb begin
    case (code)
      3'h0, 3'h5: {hookN, gkN} = 2'b11;
      3'h1: {hookN, gkN} = {~offHook, 1'b1};
      3'h3: {hookN, gkN} = {1'b0, ~entryOff | tick};
      3'h4: {hookN, gkN} = {2{~gndKey}};
      3'h7: {hookN, gkN} = entryOff ? {1'b0, tick}
                                    : {~offHook, 1'b1};
      default: {hookN, gkN} = {~offHook, ~gndKey};
    endcase
    if (hot) {hookN, gkN} = 2'b00;
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the line state controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import line_ctrl_pkg::*;
;
  localparam int PC = 20;
  logic        clock = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, zc = 0;
  logic        hot = 0, offHook = 0, gndKey = 0, ack, rsi, hookN, gkN;
  logic        relayN;
  logic [3:0]  sel = 0;
  logic [2:0]  code;
  logic [31:0] adr = 0, wdat = 0, rdat, rv, exq[$], mkq[$];
  logic [31:0] tbl [8] = '{32'h70, 32'h31, 32'h72, 32'h63, 32'h74,
                           32'h174, 32'h176, 32'h177};
  int          errors = 0, num_checks = 0, seed = 32'haa60;
  always #2.5 clock = ~clock;
  line_state_controller #(.PULSE_CYCLES(PC), .SETTLE_CYC(4))
  i_line_state_controller (.clock, .sys_rst, .ce(1'b1), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .state_code_bit2(code[2]),
    .state_code_bit1(code[1]), .state_code_bit0(code[0]),
    .ring_sync_input(rsi), .hook_detect_n(hookN),
    .ground_key_measure_n(gkN), .ring_relay_drive_n(relayN),
    .zeroCross(zc));
  line_device_model i_line_device_model (.clock, .code, .rsi, .hot,
    .offHook, .gndKey, .hookN, .gkN, .relayN);
  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] g, e, m);
    if (m != 32'h0) begin
      num_checks++;
      if (((g ^ e) & m) !== 32'h0) begin
        errors++;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w,
      input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clock);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (ack === 1'b1) break;
    end
    r = rdat;
    {cyc, stb} <= 2'b00;
    if (n == 50) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'hf);
    logic [31:0] r;
    bus(a, 1'b1, s, d, r);
  endtask
  task automatic rd(input logic [31:0] a, e, m = 32'hffff_ffff);
    logic [31:0] r;
    exq.push_back(e);
    mkq.push_back(m);
    bus(a, 1'b0, 4'hf, 32'h0, r);
  endtask
  // polls status unchecked until the sequencer has settled on t
  task automatic idle(input logic [2:0] t);
    logic [31:0] r;
    for (int i = 0; i < 40; i++) begin
      exq.push_back(32'h0);
      mkq.push_back(32'h0);
      bus(ADDR_STATUS, 1'b0, 4'hf, 32'h0, r);
      if (r[ST_BUSY_BIT] === 1'b0 && r[2:0] === t) return;
    end
    errors++;
    print_verdict();
  endtask
  always @(posedge clock) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exq.size() == 0) check_word(rdat, ~rdat, 32'hffff_ffff);
      else check_word(rdat, exq.pop_front(), mkq.pop_front());
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    rd(ADDR_STATUS, 32'h70);
    rd(ADDR_CTRL, 32'h0);
    rd(32'h8, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CTRL, c);
      idle(c == 5 ? 3'h4 : c[2:0]);
      rd(ADDR_STATUS, tbl[c]);
    end
    wr(ADDR_STATUS, 32'h100, 4'h2);
    rd(ADDR_STATUS, 32'h77);
    wr(ADDR_CTRL, 32'h2);
    idle(3'h2);
    repeat (4) begin
      rv = $random(seed);
      {offHook, gndKey} <= rv[1:0];
      rd(ADDR_STATUS, {25'h0, 1'b1, ~rv[0], ~rv[1], 4'h2});
    end
    hot <= 1;
    rd(ADDR_STATUS, 32'h0, 32'h30);
    {hot, offHook, gndKey} <= 3'b000;
    wr(ADDR_CTRL, 32'h1);
    idle(3'h1);
    offHook <= 1;
    rd(ADDR_STATUS, 32'h61, 32'h7f);
    rd(ADDR_STATUS, 32'he1);
    offHook <= 0;
    rd(ADDR_STATUS, 32'hf1);
    wr(ADDR_STATUS, 32'h80, 4'h1);
    rd(ADDR_STATUS, 32'h71);
    wr(ADDR_CTRL, 32'h2);
    idle(3'h2);
    wr(ADDR_CTRL, 32'h9);
    idle(3'h1);
    rd(ADDR_STATUS, 32'h71);
    zc <= 1;
    @(posedge clock);
    zc <= 0;
    rd(ADDR_STATUS, 32'h31);
    repeat (PC) @(posedge clock);
    rd(ADDR_STATUS, 32'h31);
    wr(ADDR_CTRL, 32'he);
    idle(3'h6);
    wr(ADDR_CTRL, 32'h1);
    idle(3'h1);
    rd(ADDR_STATUS, 32'h31);
    wr(ADDR_CTRL, 32'h6);
    idle(3'h6);
    sys_rst <= 1;
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    rd(ADDR_STATUS, 32'h70);
    rd(ADDR_CTRL, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
